// >>> common/qdac_rb_pkg.sv
// Constants and types for the quad converter readback slave
package qdac_rb_pkg;
	// Fixed upper five bits of the seven-bit device address
	localparam logic [4:0] DEV_ADDR_FIXED = 5'h13;
	// Control byte field positions
	localparam int CTRL_PD_POS  = 0;
	localparam int CTRL_CH_LSB  = 1;
	localparam int CTRL_UPD_LSB = 4;
	localparam int CTRL_EXT_LSB = 6;
	// Transmitted fill patterns
	localparam logic [5:0] STATUS_FILL = 6'h3F;
	localparam logic [7:0] LOW_FILL    = 8'h00;
	// Power modes of a channel
	localparam logic [1:0] PM_HIZ      = 2'h0;
	localparam logic [1:0] PM_1K       = 2'h1;
	localparam logic [1:0] PM_100K     = 2'h2;
	localparam logic [1:0] PM_HIZ_ALT  = 2'h3;
	// Bit counts within a byte
	localparam logic [3:0] BITS_DONE   = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	// Reset values
	localparam logic       LINE_IDLE   = 1'b1;
	localparam logic [1:0] FIELD_RST   = 2'h0;
	localparam logic [7:0] BYTE_RST    = 8'h00;

	typedef enum logic [7:0] {
		ST_IDLE     = 8'h01,
		ST_ADDR     = 8'h02,
		ST_ADDR_ACK = 8'h04,
		ST_CTRL     = 8'h08,
		ST_CTRL_ACK = 8'h10,
		ST_TX       = 8'h20,
		ST_TX_ACK   = 8'h40,
		ST_IGNORE   = 8'h80
	} state_t;
endpackage

// >>> src/quad_dac_i2c_readback.sv
// Two-wire slave transmitter for quad converter channel readback
//
// Contract
// - Write address byte acknowledged by driving low
// - Control byte acknowledged; fields decoded by position
// - Read address acknowledged only once a control byte has been received since reset
// - Flag clear: send high then low byte
// - Flag set: status, high, low bytes
// - Data comes from last selected channel
// - Status byte: mode bits, six ones
// - High byte is channel data, MSB first
// - Mode bits select output load state
module quad_dac_i2c_readback import qdac_rb_pkg::*; (
	// Clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RST_B,
	input  wire logic       CLK_EN,
	// Two-wire bus
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE_B,
	// Address straps
	input  wire logic       PIN_ADDRESS_HI,
	input  wire logic       PIN_ADDRESS_LO,
	// Stored channel contents: mode bits 9:8, data 7:0
	input  wire logic [9:0] CH0_VALUE,
	input  wire logic [9:0] CH1_VALUE,
	input  wire logic [9:0] CH2_VALUE,
	input  wire logic [9:0] CH3_VALUE,
	// Decoded control byte and status
	output logic [1:0]      EXTENDED_ADDRESS,
	output logic [1:0]      UPDATE_MODE,
	output logic [1:0]      CHANNEL_SEL,
	output logic            POWER_DOWN_FLAG,
	output logic            READ_ACTIVE,
	output logic            LOAD_1K,
	output logic            LOAD_100K
);

	state_t      state_q;
	logic        scl_q;
	logic        sda_q;
	logic [3:0]  cnt_q;
	logic [7:0]  shift_q;
	logic [1:0]  byte_idx_q;
	logic        ack_q;
	logic        ctrl_seen_q;
	logic [9:0]  sel_val;
	logic [1:0]  last_idx;
	logic [7:0]  cur_byte;
	logic [7:0]  first_byte;
	logic [7:0]  nxt_byte;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic        addr_ok;

	function automatic logic [9:0] chan_val(input logic [1:0] s,
		input logic [9:0] c0, input logic [9:0] c1,
		input logic [9:0] c2, input logic [9:0] c3);
		case (s)
			2'h0:    chan_val = c0;
			2'h1:    chan_val = c1;
			2'h2:    chan_val = c2;
			default: chan_val = c3;
		endcase
	endfunction

	function automatic logic [7:0] byte_for(input logic [1:0] idx,
		input logic pd, input logic [9:0] v);
		if (pd && idx == 2'h0)
			byte_for = {v[9:8], STATUS_FILL};
		else if (idx == {1'b0, pd})
			byte_for = v[7:0];
		else
			byte_for = LOW_FILL;
	endfunction

	// Bus event decode
	assign rise    = CLK_EN && !scl_q && SCL;
	assign fall    = CLK_EN && scl_q && !SCL;
	assign start   = CLK_EN && scl_q && SCL && sda_q && !SDA_IN;
	assign stop    = CLK_EN && scl_q && SCL && !sda_q && SDA_IN;
	assign addr_ok = shift_q[7:1] ==
		{DEV_ADDR_FIXED, PIN_ADDRESS_HI, PIN_ADDRESS_LO};
	assign sel_val = chan_val(CHANNEL_SEL, CH0_VALUE, CH1_VALUE,
		CH2_VALUE, CH3_VALUE);
	assign last_idx = POWER_DOWN_FLAG ? 2'h2 : 2'h1;
	assign cur_byte = byte_for(byte_idx_q, POWER_DOWN_FLAG, sel_val);
	// First byte of a read, independent of the index left by the last read
	assign first_byte = byte_for(2'h0, POWER_DOWN_FLAG, sel_val);
	assign nxt_byte   = byte_for(byte_idx_q + 2'h1, POWER_DOWN_FLAG,
		sel_val);

	// Line sampling
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			scl_q <= LINE_IDLE;
			sda_q <= LINE_IDLE;
		end else if (CLK_EN) begin
			scl_q <= SCL;
			sda_q <= SDA_IN;
		end
	end

	// Protocol sequencer and data line drive
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 4'h0;
			shift_q    <= BYTE_RST;
			byte_idx_q <= 2'h0;
			ack_q      <= 1'b0;
			SDA_OUT    <= LINE_IDLE;
			SDA_OE_B   <= LINE_IDLE;
		end else if (start) begin
			state_q  <= ST_ADDR;
			cnt_q    <= 4'h0;
			SDA_OE_B <= LINE_IDLE;
		end else if (stop) begin
			state_q  <= ST_IDLE;
			SDA_OE_B <= LINE_IDLE;
		end else if (CLK_EN) begin
			case (state_q)
				ST_ADDR, ST_CTRL: begin
					if (rise) begin
						shift_q <= {shift_q[6:0], SDA_IN};
						cnt_q   <= cnt_q + 4'h1;
					end else if (fall && cnt_q == BITS_DONE) begin
						if (state_q == ST_CTRL) begin
							state_q  <= ST_CTRL_ACK;
							SDA_OUT  <= 1'b0;
							SDA_OE_B <= 1'b0;
						end else if (addr_ok &&
							(!shift_q[0] || ctrl_seen_q)) begin
							state_q  <= ST_ADDR_ACK;
							SDA_OUT  <= 1'b0;
							SDA_OE_B <= 1'b0;
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (fall) begin
						cnt_q      <= 4'h0;
						byte_idx_q <= 2'h0;
						if (shift_q[0]) begin
							state_q  <= ST_TX;
							SDA_OUT  <= first_byte[7];
							SDA_OE_B <= first_byte[7];
						end else begin
							state_q  <= ST_CTRL;
							SDA_OE_B <= LINE_IDLE;
						end
					end
				end
				ST_CTRL_ACK: begin
					if (fall) begin
						state_q  <= ST_IGNORE;
						SDA_OE_B <= LINE_IDLE;
					end
				end
				ST_TX: begin
					if (fall) begin
						cnt_q <= cnt_q + 4'h1;
						ack_q <= 1'b0;
						if (cnt_q == LAST_TX_BIT) begin
							state_q  <= ST_TX_ACK;
							SDA_OE_B <= LINE_IDLE;
						end else begin
							SDA_OUT  <= cur_byte[3'h6 - cnt_q[2:0]];
							SDA_OE_B <= cur_byte[3'h6 - cnt_q[2:0]];
						end
					end
				end
				ST_TX_ACK: begin
					if (rise) begin
						if (SDA_IN || byte_idx_q == last_idx)
							state_q <= ST_IGNORE;
						else
							ack_q <= 1'b1;
					end else if (fall && ack_q) begin
						state_q    <= ST_TX;
						cnt_q      <= 4'h0;
						byte_idx_q <= byte_idx_q + 2'h1;
						SDA_OUT    <= nxt_byte[7];
						SDA_OE_B   <= nxt_byte[7];
					end
				end
				ST_IDLE, ST_IGNORE: begin
					SDA_OE_B <= LINE_IDLE;
				end
				default: begin
					state_q  <= ST_IDLE;
					SDA_OE_B <= LINE_IDLE;
				end
			endcase
		end
	end

	// Control byte capture
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			EXTENDED_ADDRESS <= FIELD_RST;
			UPDATE_MODE      <= FIELD_RST;
			CHANNEL_SEL      <= FIELD_RST;
			POWER_DOWN_FLAG  <= 1'b0;
			ctrl_seen_q      <= 1'b0;
		end else if (CLK_EN && !start && !stop && state_q == ST_CTRL &&
			fall && cnt_q == BITS_DONE) begin
			EXTENDED_ADDRESS <= shift_q[CTRL_EXT_LSB +: 2];
			UPDATE_MODE      <= shift_q[CTRL_UPD_LSB +: 2];
			CHANNEL_SEL      <= shift_q[CTRL_CH_LSB +: 2];
			POWER_DOWN_FLAG  <= shift_q[CTRL_PD_POS];
			ctrl_seen_q      <= 1'b1;
		end
	end

	// Status and load state of the selected channel
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			READ_ACTIVE <= 1'b0;
			LOAD_1K     <= 1'b0;
			LOAD_100K   <= 1'b0;
		end else if (CLK_EN) begin
			READ_ACTIVE <= state_q == ST_TX || state_q == ST_TX_ACK;
			LOAD_1K     <= sel_val[9:8] == PM_1K;
			LOAD_100K   <= sel_val[9:8] == PM_100K;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	a_addr_ack_low: assert property (state_q == ST_ADDR_ACK |->
		!SDA_OE_B && !SDA_OUT) else $error("address ack not low");
	a_ctrl_ack_low: assert property (state_q == ST_CTRL_ACK |->
		!SDA_OE_B && !SDA_OUT) else $error("control ack not low");
	a_read_needs_ctrl: assert property ($rose(state_q == ST_TX) &&
		$past(state_q) == ST_ADDR_ACK |-> ctrl_seen_q && shift_q[0])
		else $error("read started without control byte");
	a_byte_bound: assert property (state_q == ST_TX |->
		byte_idx_q <= last_idx) else $error("too many bytes sent");
	a_status_byte: assert property (state_q == ST_TX && POWER_DOWN_FLAG &&
		byte_idx_q == 2'h0 |-> cur_byte == {sel_val[9:8], 6'h3F})
		else $error("status byte wrong");
	a_high_byte: assert property (state_q == ST_TX &&
		byte_idx_q == {1'b0, POWER_DOWN_FLAG} |-> cur_byte == sel_val[7:0])
		else $error("high byte not channel data");
	a_foreign_quiet: assert property (state_q == ST_IGNORE |=> SDA_OE_B)
		else $error("drove line while ignoring");
	a_ack_slot_free: assert property (state_q == ST_TX_ACK |-> SDA_OE_B)
		else $error("line held in master ack slot");
	a_change_clk_low: assert property ($changed(SDA_OE_B) &&
		(state_q == ST_TX || state_q == ST_TX_ACK) |-> !scl_q)
		else $error("data changed while clock high");
	a_load_decode: assert property (sel_val[9:8] == PM_1K &&
		$stable(sel_val) && CLK_EN |=> LOAD_1K && !LOAD_100K)
		else $error("load state decode wrong");

	c_read_two: cover property (state_q == ST_TX_ACK && !POWER_DOWN_FLAG
		&& byte_idx_q == 2'h1 && rise && SDA_IN);
	c_read_three: cover property (state_q == ST_TX_ACK && POWER_DOWN_FLAG
		&& byte_idx_q == 2'h2 && rise && SDA_IN);
	c_foreign: cover property (state_q == ST_IGNORE && !ctrl_seen_q);
endmodule

// >>> tb/i2c_master_model.sv
// Behavioural two-wire bus master for the readback slave
module i2c_master_model (
	// Clock and bus
	input  wire logic       CLOCK,
	input  wire logic       SDA,
	output logic            SCL,
	output logic            SDA_DRV,
	// Received results
	output logic [7:0]      RES,
	output logic            RES_OK
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		SCL = 1'b1;
		SDA_DRV = 1'b1;
		RES = 8'h00;
		RES_OK = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	// One bit: data set while clock low, sampled at end of high
	task automatic put(input logic b, output logic r);
		SDA_DRV <= b;
		wt(2);
		SCL <= 1'b1;
		wt(2);
		r = SDA;
		SCL <= 1'b0;
		wt(2);
	endtask
	task automatic start;
		SDA_DRV <= 1'b1;
		wt(2);
		SCL <= 1'b1;
		wt(2);
		SDA_DRV <= 1'b0;
		wt(2);
		SCL <= 1'b0;
		wt(2);
	endtask
	task automatic stop;
		SDA_DRV <= 1'b0;
		wt(2);
		SCL <= 1'b1;
		wt(2);
		SDA_DRV <= 1'b1;
		wt(2);
	endtask
	task automatic post(input logic [7:0] v);
		RES <= v;
		RES_OK <= 1'b1;
		wt(1);
		RES_OK <= 1'b0;
	endtask
	// Write a byte, report 1 when acknowledged
	task automatic wr(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) put(d[i], r);
		put(1'b1, r);
		post({7'h00, ~r});
	endtask
	// Read a byte, then ack or not-ack it
	task automatic rd(input logic last);
		logic [7:0] d;
		logic       r;
		for (int i = 7; i >= 0; i--) begin
			put(1'b1, r);
			d[i] = r;
		end
		put(last, r);
		post(d);
	endtask
endmodule

// >>> tb/quad_dac_i2c_readback_tb.sv
// Self-checking bench for the readback slave
module quad_dac_i2c_readback_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qdac_rb_pkg::*;
	logic       clock = 1'b0;
	logic       rst_b = 1'b0;
	logic       clk_en = 1'b1;
	logic [1:0] ext_adr;
	logic [1:0] upd_mode;
	logic [1:0] chan_sel;
	logic       pd_flag;
	logic       rd_act;
	logic       load_1k;
	logic       load_100k;
	logic [7:0] exp_fld = 8'h00;
	logic       pin_hi = 1'b0;
	logic       pin_lo = 1'b0;
	logic [9:0] ch [4] = '{default: 10'h000};
	logic       scl;
	logic       m_sda;
	logic       sda_out;
	logic       sda_oe_b;
	logic [7:0] res;
	logic       res_ok;
	wire        sda = m_sda & (sda_oe_b | sda_out);
	wire  [7:0] fld = {1'b0, ext_adr, upd_mode, chan_sel, pd_flag};
	wire  [7:0] loads = {6'h00, load_100k, load_1k};
	logic [7:0] exp_q [$];
	int         fails = 0;
	int         checked = 0;
	int         seed = 41734;
	always #2.5 clock = ~clock;
	quad_dac_i2c_readback uut (.CLOCK(clock), .RST_B(rst_b),
		.CLK_EN(clk_en), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE_B(sda_oe_b), .PIN_ADDRESS_HI(pin_hi),
		.PIN_ADDRESS_LO(pin_lo), .CH0_VALUE(ch[0]), .CH1_VALUE(ch[1]),
		.CH2_VALUE(ch[2]), .CH3_VALUE(ch[3]),
		.EXTENDED_ADDRESS(ext_adr), .UPDATE_MODE(upd_mode),
		.CHANNEL_SEL(chan_sel), .POWER_DOWN_FLAG(pd_flag),
		.READ_ACTIVE(rd_act), .LOAD_1K(load_1k), .LOAD_100K(load_100k));
	i2c_master_model mdl (.CLOCK(clock), .SDA(sda), .SCL(scl),
		.SDA_DRV(m_sda), .RES(res), .RES_OK(res_ok));
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value rx byte expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_val(input string n, input logic [7:0] e,
		input logic [7:0] s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Oldest note against each result
	always @(posedge clock) begin
		if (res_ok === 1'b1)
			cmp_byte(exp_q.size() ? exp_q.pop_front() : 8'hXX, res);
	end
	task automatic readback(input logic [1:0] c, input logic pd);
		logic [7:0] ctl;
		logic [7:0] e_ld;
		ctl = 8'($random(seed));
		ctl[2:1] = c;
		ctl[0] = pd;
		mdl.start();
		exp_q.push_back(8'h01);
		mdl.wr({DEV_ADDR_FIXED, pin_hi, pin_lo, 1'b0});
		exp_q.push_back(8'h01);
		mdl.wr(ctl);
		exp_fld = {1'b0, ctl[7:4], ctl[2:0]};
		e_ld = {6'h00, ch[c][9:8] == PM_100K, ch[c][9:8] == PM_1K};
		cmp_val("fields", exp_fld, fld);
		cmp_val("loads", e_ld, loads);
		mdl.start();
		exp_q.push_back(8'h01);
		mdl.wr({DEV_ADDR_FIXED, pin_hi, pin_lo, 1'b1});
		cmp_val("read_active", 8'h01, {7'h00, rd_act});
		if (pd) begin
			exp_q.push_back({ch[c][9:8], STATUS_FILL});
			mdl.rd(1'b0);
		end
		exp_q.push_back(ch[c][7:0]);
		mdl.rd(1'b0);
		exp_q.push_back(LOW_FILL);
		mdl.rd(1'b1);
		mdl.stop();
		cmp_val("read_active", 8'h00, {7'h00, rd_act});
		$display("test readback ch %0d pd %0b done", c, pd);
	endtask
	task automatic stop_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			pin_hi <= 1'($random(seed));
			pin_lo <= 1'($random(seed));
			foreach (ch[k]) ch[k] <= 10'($random(seed));
			repeat (2) @(posedge clock);
			ch[i % 4][9:8] <= 2'(i + 1);
			repeat (2) @(posedge clock);
			if (i == 3) begin
				mdl.start();
				exp_q.push_back(8'h00);
				mdl.wr({DEV_ADDR_FIXED, ~pin_hi, pin_lo, 1'b0});
				mdl.stop();
				$display("test foreign address done");
			end
			readback(2'(i), i[2]);
			if (i == 6) begin
				clk_en <= 1'b0;
				mdl.start();
				exp_q.push_back(8'h00);
				mdl.wr({DEV_ADDR_FIXED, pin_hi, pin_lo, 1'b0});
				mdl.stop();
				clk_en <= 1'b1;
				cmp_val("frozen fields", exp_fld, fld);
				$display("test clock enable freeze done");
			end
		end
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		stop_test();
	end
endmodule
